// >>> fpms_engine_model.sv
// Behavioural model of the protocol engine beside the sequencer
`timescale 1ns/1ps
module fpms_engine_model (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire fpms_pkg::fpms_cmd_t eng_cmd,
  input  wire fpms_pkg::fpms_det_t rx_kind,
  output fpms_pkg::fpms_det_t      det_mode,
  output logic                     det_valid,
  output logic                     eng_end_done,
  output logic                     eng_term_data,
  output logic                     eng_modem_data
);
  logic [3:0] end_q;
  logic       tog_q;
  always_ff @(posedge aclk)
  begin
    tog_q <= aresetn ? !tog_q : 1'b0;
  end
  // End sequence counts down ten cycles, with one done pulse in the tenth
  always_ff @(posedge aclk)
  begin
    if (!aresetn || eng_cmd.clear)
      end_q <= 4'h0;
    else if (eng_cmd.finish)
      end_q <= 4'ha;
    else if (end_q != 4'h0)
      end_q <= end_q - 4'h1;
  end
  assign eng_end_done = (end_q == 4'h1);
  assign det_valid = (rx_kind != fpms_pkg::det_none);
  assign det_mode = det_valid ? rx_kind : fpms_pkg::fpms_det_t'({tog_q, !tog_q});
  assign eng_term_data = tog_q;
  assign eng_modem_data = !tog_q;
endmodule

// >>> fpms_pkg.sv
// Shared constants, types and register map of the front panel mode sequencer
package fpms_pkg;

  // Mode selector positions, in stepping order
  typedef enum logic [2:0] {mode_off, standby_mode, mode_arq, mode_fec, mode_sel, receive_only_watch_mode} fpms_mode_t;
  // Mode seen by the detector of the protocol engine
  typedef enum logic [1:0] {det_none, det_arq, det_fec, det_sel} fpms_det_t;
  typedef enum logic {receiving_station_role, sending_station_role} fpms_role_t;

  typedef struct packed {
    logic step;
    logic reinit;
    logic send;
    logic over;
    logic finish;
  } fpms_sw_t;

  typedef struct packed {
    logic off;
    logic standby;
    logic arq;
    logic fec;
    logic sel;
    logic watch;
  } fpms_lamps_t;

  typedef struct packed {
    logic start;
    logic turn;
    logic finish;
    logic clear;
  } fpms_cmd_t;

  // Register byte offsets
  localparam logic [11:0] FPMS_CMD_OFS    = 12'h000;
  localparam logic [11:0] FPMS_DEFMODE_OFS = 12'h004;
  localparam logic [11:0] FPMS_STATUS_OFS = 12'h008;

  // Command register bits (write one to act)
  localparam int FPMS_CMD_STEP   = 0;
  localparam int FPMS_CMD_SEND   = 1;
  localparam int FPMS_CMD_OVER   = 2;
  localparam int FPMS_CMD_FINISH = 3;
  localparam int FPMS_CMD_REINIT = 4;

  localparam fpms_mode_t FPMS_DEFMODE_RST = standby_mode;
  localparam logic [1:0] FPMS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FPMS_RESP_SLVERR = 2'h2;

  // Timing
  localparam int FPMS_CLK_KHZ   = 20000;
  localparam int FPMS_BURST_MS  = 210;
  localparam int FPMS_CTRL_MS   = 70;
  localparam int FPMS_CYCLE_MS  = 450;
  localparam int FPMS_RESP_MS   = 240;
  localparam int FPMS_TONE_MS   = 50;
  localparam int FPMS_BURST_CYC = FPMS_BURST_MS * FPMS_CLK_KHZ;
  localparam int FPMS_CTRL_CYC  = FPMS_CTRL_MS * FPMS_CLK_KHZ;
  localparam int FPMS_CYCLE_CYC = FPMS_CYCLE_MS * FPMS_CLK_KHZ;
  localparam int FPMS_RESP_CYC  = FPMS_RESP_MS * FPMS_CLK_KHZ;
  localparam int FPMS_TONE_CYC  = FPMS_TONE_MS * FPMS_CLK_KHZ;

endpackage

// >>> fpms_sequencer.sv
// Front panel mode sequencer with AXI4-Lite register access
// Function
// RULE1: Each mode press steps off, standby, ARQ, FEC, selective FEC, monitor once.
// RULE2: A press in monitor wraps the selector back to off.
// RULE3: Every front panel switch press sounds a short tone.
// RULE4: Off disables protocol logic; modem and terminal data pass straight through.
// RULE5: Standby jumps to a detected mode, lighting standby plus that mode lamp.
// RULE6: ARQ entered by call lights ARQ and standby; local ARQ lights only ARQ.
// RULE7: FEC reception lights FEC and standby; FEC transmission lights FEC only.
// RULE8: Selective lights selective and FEC; standby added only on automatic reception.
// RULE9: Monitor never transmits and adds the received mode lamp to monitor.
// RULE10: Reset switch reinitializes logic, clears buffers, loads programmed default mode.
// RULE11: Send starts transmission in the currently selected mode.
// RULE12: Over during ARQ swaps sending and receiving station roles.
// RULE13: End requests the end-of-transmission sequence of the current mode.
// RULE14: FEC and selective sending key continuously; ARQ sending keys 47 percent bursts.
// RULE15: ARQ sending burst 210 ms, receiving answer 70 ms, cycle 450 ms.
`timescale 1ns/1ps
module fpms_sequencer #(
  parameter int BURST_CYC = fpms_pkg::FPMS_BURST_CYC,
  parameter int CTRL_CYC  = fpms_pkg::FPMS_CTRL_CYC,
  parameter int CYCLE_CYC = fpms_pkg::FPMS_CYCLE_CYC,
  parameter int RESP_CYC  = fpms_pkg::FPMS_RESP_CYC,
  parameter int TONE_CYC  = fpms_pkg::FPMS_TONE_CYC
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [11:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [11:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire fpms_pkg::fpms_sw_t sw_pins,
  input  wire fpms_pkg::fpms_det_t det_mode,
  input  wire logic               det_valid,
  input  wire logic               eng_end_done,
  input  wire logic               modem_rxd_pin,
  input  wire logic               term_txd_pin,
  input  wire logic               eng_term_data,
  input  wire logic               eng_modem_data,
  output fpms_pkg::fpms_lamps_t   lamps,
  output fpms_pkg::fpms_cmd_t     eng_cmd,
  output logic                    protocol_en,
  output logic                    tone,
  output logic                    ptt,
  output logic                    term_rxd,
  output logic                    modem_txd
);

  fpms_pkg::fpms_sw_t    sw_s1_q;
  fpms_pkg::fpms_sw_t    sw_s2_q;
  fpms_pkg::fpms_sw_t    sw_s3_q;
  fpms_pkg::fpms_sw_t    press;
  logic [1:0]            dat_s1_q;
  logic [1:0]            dat_s2_q;
  fpms_pkg::fpms_mode_t  mode_q;
  fpms_pkg::fpms_mode_t  defmode_q;
  fpms_pkg::fpms_det_t   watch_det_q;
  fpms_pkg::fpms_role_t  role_q;
  logic                  auto_q;
  logic                  tx_q;
  logic [23:0]           tone_cnt_q;
  logic [23:0]           burst_cnt_q;
  logic                  aw_q;
  logic                  w_q;
  logic [11:0]           awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  do_write;
  logic                  cmd_wr;
  logic                  step;
  logic                  send;
  logic                  over;
  logic                  finish;
  logic                  reinit;
  logic                  arq_active;
  logic                  ptt_d;
  fpms_pkg::fpms_lamps_t lamps_d;

  // Next selector position, monitor wraps to off
  function automatic fpms_pkg::fpms_mode_t next_mode(input fpms_pkg::fpms_mode_t m);
    if (m == fpms_pkg::receive_only_watch_mode)
      return fpms_pkg::mode_off; // RULE2
    return fpms_pkg::fpms_mode_t'(m + 3'h1); // RULE1
  endfunction

  // Mode selected by a detected signal type
  function automatic fpms_pkg::fpms_mode_t det_to_mode(input fpms_pkg::fpms_det_t d);
    case (d)
      fpms_pkg::det_arq: return fpms_pkg::mode_arq;
      fpms_pkg::det_fec: return fpms_pkg::mode_fec;
      default:           return fpms_pkg::mode_sel;
    endcase
  endfunction

  // Switch and data pin synchronisers
  always_ff @(posedge aclk)
  begin
    sw_s1_q  <= sw_pins;
    sw_s2_q  <= sw_s1_q;
    dat_s1_q <= {modem_rxd_pin, term_txd_pin};
    dat_s2_q <= dat_s1_q;
    if (!aresetn)
      sw_s3_q <= '0;
    else
      sw_s3_q <= sw_s2_q;
  end

  assign press = sw_s2_q & ~sw_s3_q;

  // AXI write channel capture
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign do_write      = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fpms_pkg::FPMS_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      case ({awaddr_q[11:2], 2'h0})
        fpms_pkg::FPMS_CMD_OFS, fpms_pkg::FPMS_DEFMODE_OFS, fpms_pkg::FPMS_STATUS_OFS:
          s_axi_bresp <= fpms_pkg::FPMS_RESP_OKAY;
        default:
          s_axi_bresp <= fpms_pkg::FPMS_RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  assign cmd_wr = do_write && wstrb_q[0] && ({awaddr_q[11:2], 2'h0} == fpms_pkg::FPMS_CMD_OFS);

  // Programmed default mode, kept across the reset switch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      defmode_q <= fpms_pkg::FPMS_DEFMODE_RST;
    else if (do_write && wstrb_q[0] && ({awaddr_q[11:2], 2'h0} == fpms_pkg::FPMS_DEFMODE_OFS)
             && wdata_q[2:0] <= 3'(fpms_pkg::receive_only_watch_mode))
      defmode_q <= fpms_pkg::fpms_mode_t'(wdata_q[2:0]);
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= fpms_pkg::FPMS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= fpms_pkg::FPMS_RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'h0})
        fpms_pkg::FPMS_CMD_OFS:     s_axi_rdata <= 32'h00000000;
        fpms_pkg::FPMS_DEFMODE_OFS: s_axi_rdata <= {29'h0, defmode_q};
        fpms_pkg::FPMS_STATUS_OFS:
          s_axi_rdata <= {21'h0, ptt, tone, role_q, tx_q, auto_q, watch_det_q, 1'b0, mode_q};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= fpms_pkg::FPMS_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Commands from switches or the command register
  assign step   = press.step || (cmd_wr && wdata_q[fpms_pkg::FPMS_CMD_STEP]);
  assign send   = press.send || (cmd_wr && wdata_q[fpms_pkg::FPMS_CMD_SEND]);
  assign over   = press.over || (cmd_wr && wdata_q[fpms_pkg::FPMS_CMD_OVER]);
  assign finish = press.finish || (cmd_wr && wdata_q[fpms_pkg::FPMS_CMD_FINISH]);
  assign reinit = press.reinit || (cmd_wr && wdata_q[fpms_pkg::FPMS_CMD_REINIT]);

  // Mode selector, automatic entry, transmit and role state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q      <= fpms_pkg::FPMS_DEFMODE_RST;
      auto_q      <= 1'b0;
      tx_q        <= 1'b0;
      role_q      <= fpms_pkg::receiving_station_role;
      watch_det_q <= fpms_pkg::det_none;
    end
    else if (reinit)
    begin
      mode_q      <= defmode_q; // RULE10
      auto_q      <= 1'b0;
      tx_q        <= 1'b0;
      role_q      <= fpms_pkg::receiving_station_role;
      watch_det_q <= fpms_pkg::det_none;
    end
    else if (step)
    begin
      mode_q      <= next_mode(mode_q); // RULE1
      auto_q      <= 1'b0;
      tx_q        <= 1'b0;
      role_q      <= fpms_pkg::receiving_station_role;
      watch_det_q <= fpms_pkg::det_none;
    end
    else
    begin
      case (mode_q)
        fpms_pkg::standby_mode:
          if (det_valid && det_mode != fpms_pkg::det_none)
          begin
            mode_q <= det_to_mode(det_mode); // RULE5
            auto_q <= 1'b1;
            role_q <= fpms_pkg::receiving_station_role;
          end
        fpms_pkg::receive_only_watch_mode:
          if (det_valid)
            watch_det_q <= det_mode; // RULE9
        fpms_pkg::mode_arq, fpms_pkg::mode_fec, fpms_pkg::mode_sel:
        begin
          if (send && !auto_q)
          begin
            tx_q <= 1'b1; // RULE11
            if (mode_q == fpms_pkg::mode_arq)
              role_q <= fpms_pkg::sending_station_role;
          end
          else if (over && mode_q == fpms_pkg::mode_arq && (tx_q || auto_q))
            role_q <= (role_q == fpms_pkg::sending_station_role) ? // RULE12
                      fpms_pkg::receiving_station_role : fpms_pkg::sending_station_role;
          if (eng_end_done)
          begin
            tx_q   <= 1'b0;
            role_q <= fpms_pkg::receiving_station_role;
            if (auto_q)
            begin
              mode_q <= fpms_pkg::standby_mode;
              auto_q <= 1'b0;
            end
          end
        end
        default:
          auto_q <= 1'b0;
      endcase
    end
  end

  // Engine command pulses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      eng_cmd <= '0;
    else
    begin
      eng_cmd.clear  <= reinit; // RULE10
      eng_cmd.start  <= send && !reinit && !step && !auto_q
                        && (mode_q == fpms_pkg::mode_arq || mode_q == fpms_pkg::mode_fec
                            || mode_q == fpms_pkg::mode_sel); // RULE11
      eng_cmd.turn   <= over && !reinit && !step && mode_q == fpms_pkg::mode_arq && (tx_q || auto_q); // RULE12
      eng_cmd.finish <= finish && !reinit && !step && mode_q != fpms_pkg::mode_off
                        && mode_q != fpms_pkg::receive_only_watch_mode; // RULE13
    end
  end

  // Key tone on any switch press
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tone_cnt_q <= 24'h000000;
    else if (press != '0)
      tone_cnt_q <= 24'(TONE_CYC); // RULE3
    else if (tone_cnt_q != 24'h000000)
      tone_cnt_q <= tone_cnt_q - 24'h000001;
  end

  // ARQ burst cycle timer
  assign arq_active = mode_q == fpms_pkg::mode_arq && (tx_q || auto_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !arq_active || reinit || step)
      burst_cnt_q <= 24'h000000;
    else if (burst_cnt_q == 24'(CYCLE_CYC - 1))
      burst_cnt_q <= 24'h000000; // RULE15
    else
      burst_cnt_q <= burst_cnt_q + 24'h000001;
  end

  // Transmitter keying
  always_comb
  begin
    ptt_d = 1'b0;
    if ((mode_q == fpms_pkg::mode_fec || mode_q == fpms_pkg::mode_sel) && tx_q)
      ptt_d = 1'b1; // RULE14
    else if (arq_active && role_q == fpms_pkg::sending_station_role)
      ptt_d = burst_cnt_q < 24'(BURST_CYC); // RULE14
    else if (arq_active)
      ptt_d = burst_cnt_q >= 24'(RESP_CYC) && burst_cnt_q < 24'(RESP_CYC + CTRL_CYC); // RULE15
  end

  // Mode lamps
  always_comb
  begin
    lamps_d       = '0;
    lamps_d.off   = mode_q == fpms_pkg::mode_off;
    lamps_d.arq   = mode_q == fpms_pkg::mode_arq; // RULE6
    lamps_d.fec   = mode_q == fpms_pkg::mode_fec || mode_q == fpms_pkg::mode_sel; // RULE7
    lamps_d.sel   = mode_q == fpms_pkg::mode_sel; // RULE8
    lamps_d.watch = mode_q == fpms_pkg::receive_only_watch_mode;
    lamps_d.standby = mode_q == fpms_pkg::standby_mode || (auto_q && !tx_q); // RULE5
    if (mode_q == fpms_pkg::receive_only_watch_mode)
    begin
      lamps_d.arq = watch_det_q == fpms_pkg::det_arq; // RULE9
      lamps_d.fec = watch_det_q == fpms_pkg::det_fec || watch_det_q == fpms_pkg::det_sel;
      lamps_d.sel = watch_det_q == fpms_pkg::det_sel;
    end
  end

  // Registered outputs and data path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lamps       <= '0;
      ptt         <= 1'b0;
      tone        <= 1'b0;
      protocol_en <= 1'b0;
      term_rxd    <= 1'b1;
      modem_txd   <= 1'b1;
    end
    else
    begin
      lamps       <= lamps_d;
      ptt         <= ptt_d && !reinit && !step; // RULE9
      tone        <= tone_cnt_q != 24'h000000;
      protocol_en <= mode_q != fpms_pkg::mode_off; // RULE4
      term_rxd    <= (mode_q == fpms_pkg::mode_off) ? dat_s2_q[1] : eng_term_data; // RULE4
      modem_txd   <= (mode_q == fpms_pkg::mode_off) ? dat_s2_q[0] : eng_modem_data; // RULE4
    end
  end

endmodule

// >>> fpms_sequencer_props.sv
// Port checker of the front panel mode sequencer
`timescale 1ns/1ps
module fpms_sequencer_props #(
  parameter int BURST_CYC = fpms_pkg::FPMS_BURST_CYC
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire fpms_pkg::fpms_sw_t    sw_pins,
  input wire fpms_pkg::fpms_lamps_t lamps,
  input wire fpms_pkg::fpms_cmd_t   eng_cmd,
  input wire logic                  protocol_en,
  input wire logic                  tone,
  input wire logic                  ptt
);
  // Length of the current key-down run
  logic [31:0] hi_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ptt)
      hi_q <= 32'h0;
    else
      hi_q <= hi_q + 32'h1;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_press_tone: assert property ($rose(|sw_pins) |-> ##[2:6] tone)
    else $error("no tone after press");
  a_tone_len: assert property ($rose(tone) |-> tone[*5] ##1 !tone)
    else $error("tone length wrong");
  a_off_quiet: assert property (lamps.off |-> !protocol_en && !ptt && lamps == 6'h20)
    else $error("off mode not idle");
  a_sel_fec: assert property (lamps.sel |-> lamps.fec)
    else $error("sel without fec lamp");
  a_watch_silent: assert property (lamps.watch |-> !ptt && !eng_cmd.start)
    else $error("monitor transmits");
  a_fec_hold: assert property ($rose(ptt) && lamps.fec |-> ptt[*8])
    else $error("fec key dropped");
  a_arq_burst: assert property (ptt && lamps.arq |-> hi_q < BURST_CYC)
    else $error("arq burst too long");
  a_reinit_clear: assert property ($rose(sw_pins.reinit) |-> ##[2:6] eng_cmd.clear)
    else $error("no clear on reset press");
  a_wrap_off: assert property ($rose(sw_pins.step) && lamps.watch |-> ##[2:6] lamps.off)
    else $error("no wrap to off");
  a_send_start: assert property ($rose(sw_pins.send) && lamps.fec && !lamps.standby && !lamps.watch
    |-> ##[2:6] eng_cmd.start)
    else $error("send gave no start");
  c_arq_key: cover property ($rose(ptt) && lamps.arq);
  c_turn: cover property (eng_cmd.turn);
  c_watch_fec: cover property (lamps == 6'h05);
endmodule
bind fpms_sequencer fpms_sequencer_props #(.BURST_CYC(BURST_CYC)) i_fpms_sequencer_props (.*);

// >>> front_panel_mode_sequencer_tb_top.sv
// Self-checking bench of the front panel mode sequencer
`timescale 1ns/1ps
module front_panel_mode_sequencer_tb_top;
  localparam int SW_END  = 0;
  localparam int SW_OVER = 1;
  localparam int SW_SEND = 2;
  localparam int SW_RST  = 3;
  localparam int SW_STEP = 4;
  localparam logic [5:0] ST [5] = '{6'h08, 6'h04, 6'h06, 6'h01, 6'h20};
  localparam logic [5:0] AK [3] = '{6'h18, 6'h14, 6'h16};
  logic                  aclk, aresetn;
  logic [11:0]           s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  fpms_pkg::fpms_sw_t    sw_pins;
  fpms_pkg::fpms_det_t   det_mode, rx_kind;
  logic                  det_valid, eng_end_done, eng_term_data, eng_modem_data;
  logic                  modem_rxd_pin, term_txd_pin, protocol_en, tone, ptt, term_rxd, modem_txd;
  fpms_pkg::fpms_lamps_t lamps;
  fpms_pkg::fpms_cmd_t   eng_cmd;
  logic [31:0]           n_st, n_fi, n_tu, n_cl, s0, d;
  logic [1:0]            r;
  int                    err_count, compares, hi, per;

  fpms_sequencer #(.BURST_CYC(21), .CTRL_CYC(7), .CYCLE_CYC(45), .RESP_CYC(24), .TONE_CYC(5))
    i_fpms_sequencer (.*);
  fpms_engine_model i_fpms_engine_model (.*);

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Engine command pulse counters
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      n_st <= 32'h0;
      n_fi <= 32'h0;
      n_tu <= 32'h0;
      n_cl <= 32'h0;
    end
    else
    begin
      n_st <= n_st + 32'(eng_cmd.start);
      n_fi <= n_fi + 32'(eng_cmd.finish);
      n_tu <= n_tu + 32'(eng_cmd.turn);
      n_cl <= n_cl + 32'(eng_cmd.clear);
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic lchk(input logic [5:0] e);
    chk("lamps", 32'(lamps), 32'(e));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic t1(inout int n);
    tick(1);
    n++;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic fail_to();
    err_count++;
    tally_and_finish();
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      t1(n);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end while ((s_axi_awvalid || s_axi_wvalid || s_axi_bready) && n < 100);
    if (n >= 100)
      fail_to();
  endtask
  task automatic axr(input logic [11:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      t1(n);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end while ((s_axi_arvalid || s_axi_rready) && n < 100);
    if (n >= 100)
      fail_to();
  endtask
  task automatic press(input int b);
    @(posedge aclk) sw_pins[b] <= 1'b1;
    tick(6);
    sw_pins[b] <= 1'b0;
    tick(12);
  endtask
  task automatic setmode(input logic [31:0] m);
    axw(fpms_pkg::FPMS_DEFMODE_OFS, m);
    press(SW_RST);
  endtask
  // Length of one key-down run and of one full keying cycle
  task automatic burst();
    int n;
    int a;
    n = 0;
    while (ptt === 1'b1 && n < 300) t1(n);
    while (ptt !== 1'b1 && n < 300) t1(n);
    a = n;
    while (ptt === 1'b1 && n < 300) t1(n);
    hi = n - a;
    while (ptt !== 1'b1 && n < 300) t1(n);
    per = n - a;
    if (n >= 300)
      fail_to();
  endtask

  initial
  begin
    err_count = 0;
    compares = 0;
    aresetn <= 1'b0;
    s_axi_awaddr <= 12'h0;
    s_axi_awvalid <= 1'b0;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_araddr <= 12'h0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    sw_pins <= '0;
    rx_kind <= fpms_pkg::det_none;
    modem_rxd_pin <= 1'b1;
    term_txd_pin <= 1'b1;
    tick(5);
    aresetn <= 1'b1;
    tick(2);
    lchk(6'h10);
    axr(fpms_pkg::FPMS_STATUS_OFS);
    chk("mode", d & 32'h7, 32'h1);
    axw(fpms_pkg::FPMS_DEFMODE_OFS, 32'h6);
    axr(fpms_pkg::FPMS_DEFMODE_OFS);
    chk("defmode", d, 32'h1);
    axr(12'h0fc);
    chk("rresp", 32'(r), 32'(fpms_pkg::FPMS_RESP_SLVERR));
    chk("rdata", d, 32'h0);
    axw(12'h0fc, 32'h1f);
    chk("bresp", 32'(r), 32'(fpms_pkg::FPMS_RESP_SLVERR));
    axw(fpms_pkg::FPMS_CMD_OFS, 32'h1);
    tick(3);
    lchk(6'h08);
    chk("tone", 32'(tone), 32'h0);
    s0 = n_cl;
    press(SW_RST);
    chk("clear", n_cl, s0 + 32'h1);
    lchk(6'h10);
    for (int i = 0; i < 5; i++)
    begin
      press(SW_STEP);
      lchk(ST[i]);
    end
    modem_rxd_pin <= 1'b0;
    tick(6);
    chk("term_rxd", 32'(term_rxd), 32'h0);
    chk("modem_txd", 32'(modem_txd), 32'h1);
    term_txd_pin <= 1'b0;
    modem_rxd_pin <= 1'b1;
    tick(6);
    chk("term_rxd", 32'(term_rxd), 32'h1);
    chk("modem_txd", 32'(modem_txd), 32'h0);
    chk("protocol_en", 32'(protocol_en), 32'h0);
    press(SW_STEP);
    lchk(6'h10);
    chk("protocol_en", 32'(protocol_en), 32'h1);
    chk("term_rxd", 32'(term_rxd), 32'(!eng_term_data));
    chk("modem_txd", 32'(modem_txd), 32'(!eng_modem_data));
    for (int k = 1; k < 4; k++)
    begin
      rx_kind <= fpms_pkg::fpms_det_t'(k);
      tick(8);
      lchk(AK[k - 1]);
      rx_kind <= fpms_pkg::det_none;
      press(SW_RST);
    end
    setmode(32'h5);
    lchk(6'h01);
    rx_kind <= fpms_pkg::det_fec;
    tick(8);
    lchk(6'h05);
    s0 = n_st;
    press(SW_SEND);
    chk("ptt", 32'(ptt), 32'h0);
    chk("start", n_st, s0);
    rx_kind <= fpms_pkg::det_none;
    for (int m = 3; m < 5; m++)
    begin
      setmode(32'(m));
      s0 = n_st;
      press(SW_SEND);
      tick(20);
      lchk(m == 3 ? 6'h04 : 6'h06);
      chk("ptt", 32'(ptt), 32'h1);
      chk("start", n_st, s0 + 32'h1);
      s0 = n_fi;
      press(SW_END);
      tick(20);
      chk("finish", n_fi, s0 + 32'h1);
      chk("ptt", 32'(ptt), 32'h0);
    end
    setmode(32'h2);
    press(SW_SEND);
    lchk(6'h08);
    burst();
    chk("on", hi, 32'd21);
    chk("cycle", per, 32'd45);
    s0 = n_tu;
    press(SW_OVER);
    chk("turn", n_tu, s0 + 32'h1);
    burst();
    burst();
    chk("on", hi, 32'd7);
    chk("cycle", per, 32'd45);
    axr(fpms_pkg::FPMS_STATUS_OFS);
    chk("role", (d >> 8) & 32'h1, 32'h0);
    press(SW_END);
    tick(20);
    chk("ptt", 32'(ptt), 32'h0);
    tally_and_finish();
  end
endmodule
